/* pvc_conditioner.sv */
// Purpose: Two-input process-value conditioning with bias, lag and slope
// Assumes: Sample inputs synchronous to ref_clk_i; plain register port
// Notes:   Filter tick length is a parameter so benches can shorten it
// Operation
// - Scale endpoints within -19999 to 30000
// - Reject span outside 10..30000 or low>=high
// - Scale defaults 0 and 1000 after initialisation
// - Range change applies only on YES
// - Unit has four choices, default Celsius
// - Point position 0 to 4, default 1
// - Lowest digit choice only fractional fixed ranges
// - Cold junction internal or external, default internal
// - Combining exists only in two-input configuration
// - Max, min, mean, difference, passthrough; default difference
// - Policy 0 uses in-range input alone
// - Policy 1 keeps result and flags over
// - Policy ignored in difference mode
// - Independent bias, filter, slope per input
// - Bias -10000 to 10000, default 0
// - Lag filter off or 1..100 s
// - Slope 0.500 to 1.500 linear only
// - Value equals input times slope plus bias
// - Slope applies after upstream linearising stages
`timescale 1ns/1ps
`default_nettype none
module pvc_conditioner #(
   parameter int TICK_CYCLES = pvc_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                         ref_clk_i,
   input  wire logic                         rst_b_i,
   // Register port
   input  wire logic [pvc_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic [pvc_pkg::DATA_W-1:0]   reg_wdata_i,
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   output logic [pvc_pkg::DATA_W-1:0]        reg_rdata_o,
   // Configuration straps and range attributes
   input  wire logic                         two_input_i,
   input  wire logic                         range_fraction_i,
   // Samples from the converter
   input  wire pvc_pkg::pvc_sample_type      sample0_i,
   input  wire pvc_pkg::pvc_sample_type      sample1_i,
   input  wire logic                         sample_valid_i,
   // Execution value towards control
   output logic signed [pvc_pkg::OUT_W-1:0]  pv_o,
   output logic                              pv_over_o,
   output logic                              pv_valid_o,
   // Display and compensation settings
   output logic [7:0]                        range_o,
   output logic [1:0]                        unit_o,
   output logic [2:0]                        point_o,
   output logic                              digit_short_o,
   output logic                              cjc_external_o
);
   localparam int OW = pvc_pkg::OUT_W;

   logic [7:0]               range_reg, range_pend_reg;
   logic signed [15:0]       sc_low_reg, sc_high_reg;
   logic [1:0]               unit_reg;
   logic [2:0]               point_reg, mode_reg;
   logic                     digit_reg, cjc_reg, policy_reg, rej_reg;
   logic [15:0]              rdata_reg;
   logic [31:0]              tick_cnt_reg;
   logic                     tick_reg, s1_reg, valid_reg, over_reg;
   logic signed [OW-1:0]     pv_reg;
   pvc_pkg::pvc_chan_type    chan_reg [2];
   pvc_pkg::pvc_sample_type  samp_reg [2];
   logic signed [OW-1:0]     val [2];

   // Range classification
   wire logic is_thermo = range_reg <= pvc_pkg::RANGE_THERMO_LAST;
   wire logic is_lin = range_reg >= pvc_pkg::RANGE_LIN_FIRST;

   // Write decode
   wire logic wr_range  = reg_wr_i && reg_addr_i == pvc_pkg::ADR_RANGE;
   wire logic wr_conf   = reg_wr_i && reg_addr_i == pvc_pkg::ADR_CONFIRM;
   wire logic confirm   = wr_conf && reg_wdata_i[0];
   wire logic wr_low    = reg_wr_i && reg_addr_i == pvc_pkg::ADR_SC_LOW;
   wire logic wr_high   = reg_wr_i && reg_addr_i == pvc_pkg::ADR_SC_HIGH;
   wire logic wr_unit   = reg_wr_i && reg_addr_i == pvc_pkg::ADR_UNIT;
   wire logic wr_point  = reg_wr_i && reg_addr_i == pvc_pkg::ADR_POINT;
   wire logic wr_digit  = reg_wr_i && reg_addr_i == pvc_pkg::ADR_DIGIT;
   wire logic wr_cjc    = reg_wr_i && reg_addr_i == pvc_pkg::ADR_CJC;
   wire logic wr_comb   = reg_wr_i && reg_addr_i == pvc_pkg::ADR_COMBINE;

   // Scale endpoint checks
   wire logic signed [17:0] wv   = {{2{reg_wdata_i[15]}}, reg_wdata_i};
   wire logic signed [17:0] lo18 = {{2{sc_low_reg[15]}}, sc_low_reg};
   wire logic signed [17:0] hi18 = {{2{sc_high_reg[15]}}, sc_high_reg};
   wire logic signed [17:0] span_l = hi18 - wv;
   wire logic signed [17:0] span_h = wv - lo18;
   wire logic in_cnt = wv >= pvc_pkg::SC_MIN && wv <= pvc_pkg::SC_MAX;
   wire logic ok_low  = is_lin && in_cnt && span_l >= pvc_pkg::SPAN_MIN
                        && span_l <= pvc_pkg::SPAN_MAX;
   wire logic ok_high = is_lin && in_cnt && span_h >= pvc_pkg::SPAN_MIN
                        && span_h <= pvc_pkg::SPAN_MAX;
   wire logic ok_point = is_lin && reg_wdata_i <= 16'(pvc_pkg::POINT_MAX);
   wire logic ok_digit = !is_lin && range_fraction_i;
   wire logic ok_mode  = two_input_i && reg_wdata_i[2:0] <= pvc_pkg::MODE_PASS
                         && reg_wdata_i[15:4] == 12'h000;
   wire logic new_diff = reg_wdata_i[2:0] == pvc_pkg::MODE_DIFF;

   // Per-input setting checks
   wire logic signed [15:0] ws = reg_wdata_i;
   wire logic ok_bias  = ws >= pvc_pkg::BIAS_MIN && ws <= pvc_pkg::BIAS_MAX;
   wire logic ok_tau   = reg_wdata_i <= pvc_pkg::TAU_MAX;
   wire logic ok_slope = is_lin && reg_wdata_i >= pvc_pkg::SLOPE_MIN
                         && reg_wdata_i <= pvc_pkg::SLOPE_MAX;
   wire logic [3:0] rel_b = reg_addr_i - pvc_pkg::ADR_BIAS0;
   wire logic [3:0] rel_t = reg_addr_i - pvc_pkg::ADR_TAU0;
   wire logic [3:0] rel_s = reg_addr_i - pvc_pkg::ADR_SLOPE0;
   wire logic wr_bias  = reg_wr_i && rel_b < 4'h2;
   wire logic wr_tau   = reg_wr_i && rel_t < 4'h2;
   wire logic wr_slope = reg_wr_i && rel_s < 4'h2;
   wire logic ch_sel_b = rel_b[0];
   wire logic ch_sel_t = rel_t[0];
   wire logic ch_sel_s = rel_s[0];
   wire logic ch1_ok   = two_input_i;

   wire logic bad_wr = (wr_low && !ok_low) || (wr_high && !ok_high)
      || (wr_point && !ok_point) || (wr_digit && !ok_digit)
      || (wr_cjc && !is_thermo) || (wr_comb && !ok_mode)
      || (wr_bias && (!ok_bias || (ch_sel_b && !ch1_ok)))
      || (wr_tau && (!ok_tau || (ch_sel_t && !ch1_ok)))
      || (wr_slope && (!ok_slope || (ch_sel_s && !ch1_ok)));

   // Read mux
   wire logic [15:0] status_word = {10'h000, two_input_i, is_thermo, is_lin,
                                    pv_over_o, 1'b0, rej_reg};
   wire logic [15:0] rd_mux =
      reg_addr_i == pvc_pkg::ADR_RANGE   ? {8'h00, range_reg} :
      reg_addr_i == pvc_pkg::ADR_CONFIRM ? {8'h00, range_pend_reg} :
      reg_addr_i == pvc_pkg::ADR_SC_LOW  ? sc_low_reg :
      reg_addr_i == pvc_pkg::ADR_SC_HIGH ? sc_high_reg :
      reg_addr_i == pvc_pkg::ADR_UNIT    ? {14'h0000, unit_reg} :
      reg_addr_i == pvc_pkg::ADR_POINT   ? {13'h0000, point_reg} :
      reg_addr_i == pvc_pkg::ADR_DIGIT   ? {15'h0000, digit_reg} :
      reg_addr_i == pvc_pkg::ADR_CJC     ? {15'h0000, cjc_reg} :
      reg_addr_i == pvc_pkg::ADR_COMBINE ? {12'h000, policy_reg, mode_reg} :
      rel_b < 4'h2 ? chan_reg[rel_b[0]].bias :
      rel_t < 4'h2 ? {9'h000, chan_reg[rel_t[0]].tau} :
      rel_s < 4'h2 ? {4'h0, chan_reg[rel_s[0]].slope} :
      status_word;

   // Global settings and range change handshake
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         range_reg      <= pvc_pkg::RANGE_DEF;
         range_pend_reg <= pvc_pkg::RANGE_DEF;
         sc_low_reg     <= pvc_pkg::SC_LOW_DEF;
         sc_high_reg    <= pvc_pkg::SC_HIGH_DEF;
         unit_reg       <= pvc_pkg::UNIT_DEG_C;
         point_reg      <= pvc_pkg::POINT_DEF;
         digit_reg      <= 1'b0;
         cjc_reg        <= 1'b0;
         mode_reg       <= pvc_pkg::MODE_DEF;
         policy_reg     <= 1'b0;
         rej_reg        <= 1'b0;
      end else begin
         if (wr_range)
            range_pend_reg <= reg_wdata_i[7:0];
         if (confirm) begin
            range_reg   <= range_pend_reg;
            sc_low_reg  <= pvc_pkg::SC_LOW_DEF;
            sc_high_reg <= pvc_pkg::SC_HIGH_DEF;
            point_reg   <= pvc_pkg::POINT_DEF;
            digit_reg   <= 1'b0;
            cjc_reg     <= 1'b0;
         end else begin
            if (wr_low && ok_low)
               sc_low_reg <= reg_wdata_i;
            if (wr_high && ok_high)
               sc_high_reg <= reg_wdata_i;
            if (wr_point && ok_point)
               point_reg <= reg_wdata_i[2:0];
            if (wr_digit && ok_digit)
               digit_reg <= reg_wdata_i[0];
            if (wr_cjc && is_thermo)
               cjc_reg <= reg_wdata_i[0];
         end
         if (wr_conf && !reg_wdata_i[0])
            range_pend_reg <= range_reg;
         if (wr_unit)
            unit_reg <= reg_wdata_i[1:0];
         if (wr_comb && ok_mode) begin
            mode_reg <= reg_wdata_i[2:0];
            if (!new_diff)
               policy_reg <= reg_wdata_i[3];
         end
         if (reg_wr_i)
            rej_reg <= bad_wr;
      end
   end

   // Read data stands in the cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i)
         rdata_reg <= 16'h0000;
      else if (reg_rd_i)
         rdata_reg <= rd_mux;
      else
         rdata_reg <= 16'h0000;
   end

   // Filter sample tick divider
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         tick_reg     <= 1'b0;
      end
   end

   // Per-input sample, lag filter, slope and bias
   genvar g;
   for (g = 0; g < 2; g++) begin : g_chan
      logic signed [pvc_pkg::ACC_W-1:0] acc_reg;
      wire logic signed [pvc_pkg::ACC_W-1:0] tgt =
         {samp_reg[g].value, 8'h00};
      wire logic signed [pvc_pkg::ACC_W:0] diff =
         {tgt[pvc_pkg::ACC_W-1], tgt} - {acc_reg[pvc_pkg::ACC_W-1], acc_reg};
      wire logic [11:0] tau_x = 12'(chan_reg[g].tau * pvc_pkg::TICKS_PER_S);
      wire logic signed [pvc_pkg::ACC_W:0] divr = {13'h0000, tau_x};
      wire logic signed [pvc_pkg::ACC_W:0] step = diff / divr;
      wire logic filt_off = chan_reg[g].tau == 7'h00;
      wire logic signed [15:0] fv = filt_off ? samp_reg[g].value
         : acc_reg[pvc_pkg::ACC_W-1:pvc_pkg::FRAC_W];
      wire logic [11:0] slope_eff = is_lin ? chan_reg[g].slope
         : pvc_pkg::SLOPE_ONE;
      wire logic signed [27:0] prod = fv * $signed({1'b0, slope_eff[10:0]});
      wire logic signed [27:0] scl  = prod / $signed({16'h0000,
                                      pvc_pkg::SLOPE_ONE});
      // Upstream linearising stages are already applied to the sample
      assign val[g] = scl[OW-1:0]
         + {{(OW-16){chan_reg[g].bias[15]}}, chan_reg[g].bias};

      wire logic wb = wr_bias && ch_sel_b == 1'(g) && ok_bias
                      && (g == 0 || ch1_ok);
      wire logic wt = wr_tau && ch_sel_t == 1'(g) && ok_tau
                      && (g == 0 || ch1_ok);
      wire logic ws_ = wr_slope && ch_sel_s == 1'(g) && ok_slope
                       && (g == 0 || ch1_ok);

      always_ff @(posedge ref_clk_i) begin
         if (!rst_b_i) begin
            chan_reg[g].bias  <= 16'sh0000;
            chan_reg[g].tau   <= 7'h00;
            chan_reg[g].slope <= pvc_pkg::SLOPE_ONE;
         end else if (confirm) begin
            chan_reg[g].bias  <= 16'sh0000;
            chan_reg[g].tau   <= 7'h00;
            chan_reg[g].slope <= pvc_pkg::SLOPE_ONE;
         end else begin
            if (wb)
               chan_reg[g].bias <= reg_wdata_i;
            if (wt)
               chan_reg[g].tau <= reg_wdata_i[6:0];
            if (ws_)
               chan_reg[g].slope <= reg_wdata_i[11:0];
         end
      end

      always_ff @(posedge ref_clk_i) begin
         if (!rst_b_i) begin
            samp_reg[g] <= '0;
            acc_reg     <= '0;
         end else begin
            if (sample_valid_i)
               samp_reg[g] <= (g == 0) ? sample0_i : sample1_i;
            if (filt_off)
               acc_reg <= tgt;
            else if (tick_reg)
               acc_reg <= acc_reg + step[pvc_pkg::ACC_W-1:0];
         end
      end
   end

   // Two-input combining
   wire logic ov0 = samp_reg[0].over;
   wire logic ov1 = samp_reg[1].over;
   wire logic signed [OW:0] sum01 = {val[0][OW-1], val[0]}
                                  + {val[1][OW-1], val[1]};
   wire logic signed [OW-1:0] mean01 = sum01[OW:1];
   wire logic mma = mode_reg == pvc_pkg::MODE_MAX
                 || mode_reg == pvc_pkg::MODE_MIN
                 || mode_reg == pvc_pkg::MODE_MEAN;
   wire logic use_single = !policy_reg && mma && (ov0 ^ ov1);
   wire logic signed [OW-1:0] good = ov0 ? val[1] : val[0];
   wire logic signed [OW-1:0] comb_raw =
      mode_reg == pvc_pkg::MODE_MAX  ? (val[0] > val[1] ? val[0] : val[1]) :
      mode_reg == pvc_pkg::MODE_MIN  ? (val[0] < val[1] ? val[0] : val[1]) :
      mode_reg == pvc_pkg::MODE_MEAN ? mean01 :
      mode_reg == pvc_pkg::MODE_DIFF ? val[0] - val[1] :
      val[0];
   wire logic signed [OW-1:0] comb = !two_input_i ? val[0]
      : use_single ? good : comb_raw;
   wire logic over_comb = !two_input_i ? ov0
      : mode_reg == pvc_pkg::MODE_PASS ? ov0
      : (!policy_reg && mma) ? (ov0 && ov1)
      : (ov0 || ov1);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         pv_reg    <= '0;
         over_reg  <= 1'b0;
         s1_reg    <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         pv_reg    <= comb;
         over_reg  <= over_comb;
         s1_reg    <= sample_valid_i;
         valid_reg <= s1_reg;
      end
   end

   assign reg_rdata_o    = rdata_reg;
   assign pv_o           = pv_reg;
   assign pv_over_o      = over_reg;
   assign pv_valid_o     = valid_reg;
   assign range_o        = range_reg;
   assign unit_o         = unit_reg;
   assign point_o        = point_reg;
   assign digit_short_o  = digit_reg;
   assign cjc_external_o = cjc_reg;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_scale_in_range: assert property (
      sc_low_reg >= 16'(pvc_pkg::SC_MIN) && sc_high_reg <= 16'sh7530)
      else $error("scale endpoint outside count range");
   a_scale_span_ok: assert property (
      (hi18 - lo18) >= pvc_pkg::SPAN_MIN && (hi18 - lo18) <= pvc_pkg::SPAN_MAX)
      else $error("scale span out of bounds");
   a_confirm_defaults: assert property (
      confirm |=> sc_low_reg == 16'sh0000 && sc_high_reg == 16'sh03e8)
      else $error("scale not reset after confirm");
   a_decline_keeps_range: assert property (
      (wr_conf && !reg_wdata_i[0]) |=> $stable(range_reg)
         && $stable(sc_low_reg) && $stable(sc_high_reg))
      else $error("declined change altered settings");
   a_point_limit: assert property (
      point_reg <= pvc_pkg::POINT_MAX)
      else $error("point position above four");
   a_digit_locked: assert property (
      (wr_digit && is_lin && !confirm) |=> $stable(digit_reg))
      else $error("digit selection changed on linear range");
   a_single_input_pass: assert property (
      !two_input_i |=> pv_reg == $past(val[0]))
      else $error("single-input value not passed through");
   a_diff_value: assert property (
      (two_input_i && mode_reg == pvc_pkg::MODE_DIFF)
         |=> pv_reg == $past(val[0]) - $past(val[1]))
      else $error("difference mode value wrong");
   a_policy0_pick: assert property (
      (two_input_i && !policy_reg && mma && ov0 && !ov1)
         |=> pv_reg == $past(val[1]) && !pv_over_o)
      else $error("in-range input not chosen");
   a_policy1_flag: assert property (
      (two_input_i && policy_reg && (ov0 || ov1)
         && mode_reg != pvc_pkg::MODE_PASS) |=> pv_over_o)
      else $error("over not flagged under policy one");
   a_bias_limit: assert property (
      chan_reg[0].bias >= pvc_pkg::BIAS_MIN
         && chan_reg[0].bias <= pvc_pkg::BIAS_MAX)
      else $error("bias outside limits");
   a_slope_tau_limit: assert property (
      chan_reg[0].slope >= 12'h1f4 && chan_reg[0].slope <= 12'h5dc
         && chan_reg[0].tau <= 7'h64)
      else $error("slope or time constant outside limits");
   a_valid_latency: assert property (
      sample_valid_i |-> ##2 pv_valid_o)
      else $error("valid pulse misplaced");

   c_confirm_seen: cover property (wr_range ##[1:8] confirm);
   c_policy0_single: cover property (two_input_i && use_single);
   c_filter_step: cover property (tick_reg && chan_reg[0].tau != 7'h00);
   c_rejected_write: cover property (reg_wr_i && bad_wr);
endmodule // pvc_conditioner
`default_nettype wire

/* pvc_conv_model.sv */
// Purpose: Converter model feeding two samples on request
// Assumes: Requests arrive just after a rising edge
// Notes:   Data lines scramble outside the valid cycle
`timescale 1ns/1ps
`default_nettype none
module pvc_conv_model (
   // Clock and request
   input  wire logic                    ref_clk_i,
   input  wire logic                    go_i,
   input  wire pvc_pkg::pvc_sample_type s0_i,
   input  wire pvc_pkg::pvc_sample_type s1_i,
   // Converter side
   output var pvc_pkg::pvc_sample_type  sample0_o,
   output var pvc_pkg::pvc_sample_type  sample1_o,
   output logic                         sample_valid_o
);
   always_ff @(posedge ref_clk_i) begin
      sample_valid_o <= go_i;
      sample0_o      <= go_i ? s0_i : ~sample0_o;
      sample1_o      <= go_i ? s1_i : ~sample1_o;
   end
endmodule // pvc_conv_model
`default_nettype wire

/* pvc_pkg.sv */
// Purpose: Constants and carrier types for the process-value conditioner
// Assumes: 250 MHz reference clock, 16-bit register port
// Notes:   Values are counts in display units; slope is in thousandths
package pvc_pkg;
   localparam int VAL_W  = 16;
   localparam int OUT_W  = 20;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int ACC_W  = 24;
   localparam int FRAC_W = 8;

   // Register offsets
   localparam logic [3:0] ADR_RANGE   = 4'h0;
   localparam logic [3:0] ADR_CONFIRM = 4'h1;
   localparam logic [3:0] ADR_SC_LOW  = 4'h2;
   localparam logic [3:0] ADR_SC_HIGH = 4'h3;
   localparam logic [3:0] ADR_UNIT    = 4'h4;
   localparam logic [3:0] ADR_POINT   = 4'h5;
   localparam logic [3:0] ADR_DIGIT   = 4'h6;
   localparam logic [3:0] ADR_CJC     = 4'h7;
   localparam logic [3:0] ADR_COMBINE = 4'h8;
   localparam logic [3:0] ADR_BIAS0   = 4'h9;
   localparam logic [3:0] ADR_TAU0    = 4'hb;
   localparam logic [3:0] ADR_SLOPE0  = 4'hd;
   localparam logic [3:0] ADR_STATUS  = 4'hf;

   // Scaling limits and defaults
   localparam logic signed [17:0] SC_MIN      = -18'sh04e1f;
   localparam logic signed [17:0] SC_MAX      = 18'sh07530;
   localparam logic signed [17:0] SPAN_MIN    = 18'sh0000a;
   localparam logic signed [17:0] SPAN_MAX    = 18'sh07530;
   localparam logic signed [15:0] SC_LOW_DEF  = 16'sh0000;
   localparam logic signed [15:0] SC_HIGH_DEF = 16'sh03e8;

   // Per-input compensation limits and defaults
   localparam logic signed [15:0] BIAS_MIN  = -16'sh2710;
   localparam logic signed [15:0] BIAS_MAX  = 16'sh2710;
   localparam logic [15:0]        TAU_MAX   = 16'h0064;
   localparam logic [15:0]        SLOPE_MIN = 16'h01f4;
   localparam logic [15:0]        SLOPE_MAX = 16'h05dc;
   localparam logic [11:0]        SLOPE_ONE = 12'h3e8;

   // Range codes: thermocouple, resistance sensor, linear
   localparam logic [7:0] RANGE_THERMO_LAST = 8'h13;
   localparam logic [7:0] RANGE_RES_FIRST = 8'h1f;
   localparam logic [7:0] RANGE_RES_LAST  = 8'h3a;
   localparam logic [7:0] RANGE_LIN_FIRST = 8'h47;
   localparam logic [7:0] RANGE_DEF       = 8'h47;

   // Unit codes, point position, combine modes
   localparam logic [1:0] UNIT_DEG_C  = 2'h0;
   localparam logic [2:0] POINT_MAX   = 3'h4;
   localparam logic [2:0] POINT_DEF   = 3'h1;
   localparam logic [2:0] MODE_MAX    = 3'h0;
   localparam logic [2:0] MODE_MIN    = 3'h1;
   localparam logic [2:0] MODE_MEAN   = 3'h2;
   localparam logic [2:0] MODE_DIFF   = 3'h3;
   localparam logic [2:0] MODE_PASS   = 3'h4;
   localparam logic [2:0] MODE_DEF    = 3'h3;

   // Filter sample tick: 100 ms at a 4 ns clock
   localparam int CLK_PERIOD_NS  = 4;
   localparam int TICK_PERIOD_MS = 100;
   localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TICKS_PER_S    = 1000 / TICK_PERIOD_MS;

   typedef struct packed {
      logic signed [VAL_W-1:0] bias;
      logic [6:0]              tau;
      logic [11:0]             slope;
   } pvc_chan_type;

   typedef struct packed {
      logic signed [VAL_W-1:0] value;
      logic                    over;
   } pvc_sample_type;
endpackage

/* tb_pv_input_conditioning.sv */
// Purpose: Self-checking bench for the process-value conditioner
// Assumes: Converter model drives samples; bench drives registers
// Notes:   Drivers queue expected results; a monitor compares them
`timescale 1ns/1ps
`default_nettype none
module tb_pv_input_conditioning;
   logic ref_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0, go = 1'b0, rd_d = 1'b0;
   logic two_input_i = 1'b1, range_fraction_i = 1'b0;
   logic [3:0]              reg_addr_i = 4'h0;
   logic [15:0]             reg_wdata_i = 16'h0000;
   pvc_pkg::pvc_sample_type s0 = '0, s1 = '0, sample0_i, sample1_i;
   wire logic sample_valid_i, pv_over_o, pv_valid_o, digit_short_o;
   wire logic               cjc_external_o;
   wire logic [15:0]        reg_rdata_o;
   wire logic signed [19:0] pv_o;
   wire logic [7:0]         range_o;
   wire logic [1:0]         unit_o;
   wire logic [2:0]         point_o;
   logic [20:0]             pv_q[$], rd_q[$];
   int bad_count = 0, checked = 0, cycles = 0, a, b, e;

   always #2 ref_clk_i = ~ref_clk_i;
   pvc_conditioner #(.TICK_CYCLES(8)) dut (.ref_clk_i, .rst_b_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .two_input_i, .range_fraction_i, .sample0_i, .sample1_i,
      .sample_valid_i, .pv_o, .pv_over_o, .pv_valid_o, .range_o, .unit_o,
      .point_o, .digit_short_o, .cjc_external_o);
   pvc_conv_model conv (.ref_clk_i, .go_i(go), .s0_i(s0), .s1_i(s1),
      .sample0_o(sample0_i), .sample1_o(sample1_i),
      .sample_valid_o(sample_valid_i));

   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      reg_addr_i  <= ad;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [3:0] ad, input logic [15:0] d);
      reg_addr_i <= ad;
      reg_rd_i   <= 1'b1;
      rd_q.push_back({5'h00, d});
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic snd(input int x, y, input logic ox, oy, input int ex,
                      input logic eo);
      s0 <= {x[15:0], ox};
      s1 <= {y[15:0], oy};
      go <= 1'b1;
      pv_q.push_back({eo, ex[19:0]});
      @(posedge ref_clk_i);
      go <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask

   // Read data lands one cycle after the strobe; ceiling cuts a hang
   always @(posedge ref_clk_i) begin
      rd_d   <= reg_rd_i;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   always @(negedge ref_clk_i) begin
      if (rd_d) chk({5'h00, reg_rdata_o}, rd_q.pop_front());
      if (pv_valid_o) chk({pv_over_o, pv_o}, pv_q.pop_front());
   end

   initial begin
      void'($urandom(37));
      repeat (5) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      rd(pvc_pkg::ADR_SC_LOW, 16'h0000);
      rd(pvc_pkg::ADR_SC_HIGH, 16'h03e8);
      rd(pvc_pkg::ADR_UNIT, 16'h0000);
      rd(pvc_pkg::ADR_POINT, 16'h0001);
      rd(pvc_pkg::ADR_CJC, 16'h0000);
      rd(pvc_pkg::ADR_BIAS0, 16'h0000);
      rd(pvc_pkg::ADR_SLOPE0, 16'h03e8);
      chk({6'h00, range_o, unit_o, point_o, digit_short_o, cjc_external_o},
          {6'h00, 8'h47, 2'h0, 3'h1, 2'h0});
      $display("defaults done");
      wr(pvc_pkg::ADR_SC_LOW, 16'hb1e0);
      rd(pvc_pkg::ADR_STATUS, 16'h0029);
      wr(pvc_pkg::ADR_SC_HIGH, 16'h0009);
      wr(pvc_pkg::ADR_SC_HIGH, 16'h000a);
      rd(pvc_pkg::ADR_STATUS, 16'h0028);
      wr(pvc_pkg::ADR_SC_LOW, 16'h000a);
      rd(pvc_pkg::ADR_SC_LOW, 16'h0000);
      wr(pvc_pkg::ADR_POINT, 16'h0005);
      rd(pvc_pkg::ADR_POINT, 16'h0001);
      wr(pvc_pkg::ADR_DIGIT, 16'h0001);
      rd(pvc_pkg::ADR_DIGIT, 16'h0000);
      wr(pvc_pkg::ADR_UNIT, 16'h0003);
      $display("settings done");
      for (int m = 0; m < 5; m++) begin
         a = int'($urandom_range(16000)) - 8000;
         b = int'($urandom_range(16000)) - 8000;
         wr(pvc_pkg::ADR_COMBINE, 16'(m));
         e = (m == 0) ? (a > b ? a : b) : (m == 1) ? (a < b ? a : b) :
             (m == 2) ? (a + b) >>> 1 : (m == 3) ? a - b : a;
         snd(a, b, 1'b0, 1'b0, e, 1'b0);
      end
      $display("combine done");
      wr(pvc_pkg::ADR_BIAS0, 16'h0064);
      wr(pvc_pkg::ADR_BIAS0, 16'h2711);
      rd(pvc_pkg::ADR_BIAS0, 16'h0064);
      wr(pvc_pkg::ADR_SLOPE0 + 4'h1, 16'h01f4);
      wr(pvc_pkg::ADR_COMBINE, 16'h0003);
      snd(a, b, 1'b0, 1'b0, a + 100 - b * 500 / 1000, 1'b0);
      wr(pvc_pkg::ADR_COMBINE, 16'h0000);
      snd(a, b, 1'b0, 1'b1, a + 100, 1'b0);
      snd(a, b, 1'b1, 1'b0, b * 500 / 1000, 1'b0);
      wr(pvc_pkg::ADR_COMBINE, 16'h0008);
      e = a + 100 > b * 500 / 1000 ? a + 100 : b * 500 / 1000;
      snd(a, b, 1'b0, 1'b1, e, 1'b1);
      wr(pvc_pkg::ADR_COMBINE, 16'h0003);
      rd(pvc_pkg::ADR_COMBINE, 16'h000b);
      $display("compensation done");
      wr(pvc_pkg::ADR_RANGE, 16'h0005);
      wr(pvc_pkg::ADR_CONFIRM, 16'h0000);
      rd(pvc_pkg::ADR_CONFIRM, 16'h0047);
      rd(pvc_pkg::ADR_BIAS0, 16'h0064);
      wr(pvc_pkg::ADR_RANGE, 16'h0005);
      wr(pvc_pkg::ADR_CONFIRM, 16'h0001);
      rd(pvc_pkg::ADR_BIAS0, 16'h0000);
      rd(pvc_pkg::ADR_UNIT, 16'h0003);
      wr(pvc_pkg::ADR_CJC, 16'h0001);
      rd(pvc_pkg::ADR_CJC, 16'h0001);
      range_fraction_i <= 1'b1;
      wr(pvc_pkg::ADR_DIGIT, 16'h0001);
      chk({6'h00, range_o, unit_o, point_o, digit_short_o, cjc_external_o},
          {6'h00, 8'h05, 2'h3, 3'h1, 2'h3});
      wr(pvc_pkg::ADR_SLOPE0, 16'h01f4);
      rd(pvc_pkg::ADR_SLOPE0, 16'h03e8);
      wr(pvc_pkg::ADR_TAU0, 16'h0065);
      rd(pvc_pkg::ADR_TAU0, 16'h0000);
      two_input_i <= 1'b0;
      wr(pvc_pkg::ADR_COMBINE, 16'h0000);
      rd(pvc_pkg::ADR_COMBINE, 16'h000b);
      snd(a, b, 1'b0, 1'b1, a, 1'b0);
      wr(pvc_pkg::ADR_TAU0, 16'h0001);
      snd(b, b, 1'b0, 1'b0, a, 1'b0);
      $display("range done");
      print_verdict();
   end
endmodule // tb_pv_input_conditioning
`default_nettype wire
